// ===== eipr_map.svh
`ifndef EIPR_MAP_SVH
`define EIPR_MAP_SVH

// register offsets on the 8-bit special register port
`define EIPR_ADR_EXT_ENABLE_1    8'had
`define EIPR_ADR_EXT_PRIO_LOW_1  8'hae
`define EIPR_ADR_EXT_PRIO_HIGH_1 8'haf
`define EIPR_ADR_BASE_PRIO_HIGH  8'hb7
`define EIPR_ADR_BASE_PRIO_LOW   8'hb8
`define EIPR_ADR_EXTRA_EXT_CTL   8'hc0
`define EIPR_ADR_EXT_ENABLE_2    8'haa
`define EIPR_ADR_SYS_FLAG_ENABLE 8'hab

// reset values
`define EIPR_RST_BYTE            8'h00
`define EIPR_RST_SEVEN           7'h00
`define EIPR_RST_THREE           3'h0

// extra external control field positions
`define EIPR_B_THIRD_POL         7
`define EIPR_B_THIRD_EN          6
`define EIPR_B_THIRD_FLAG        5
`define EIPR_B_THIRD_TYPE        4
`define EIPR_B_SECOND_POL        3
`define EIPR_B_SECOND_EN         2
`define EIPR_B_SECOND_FLAG       1
`define EIPR_B_SECOND_TYPE       0

// extended enable 1 field positions
`define EIPR_B_TWO_WIRE_SERIAL_EN           6
`define EIPR_B_KEYPAD_EN         5
`define EIPR_B_UART2_EN          4
`define EIPR_B_SYSFLAG_EN        3
`define EIPR_B_COUNTER_EN        2
`define EIPR_B_CONVERTER_EN      1
`define EIPR_B_SERPER_EN         0

// source numbering, also the position in the priority vectors
`define EIPR_SRC_COUNT           16
`define EIPR_SRC_SECOND_EXT      4'h6
`define EIPR_SRC_THIRD_EXT       4'h7
`define EIPR_SRC_SYSFLAG         11
`define EIPR_SRC_KEYPAD          13

`endif

// ===== eipr_pkg.sv
package eipr_pkg;

	// priority code {high bit, low bit}; 2'b11 is the most urgent level
	typedef logic [1:0] eipr_level_t;

	// index of one of the sixteen request sources
	typedef logic [3:0] eipr_src_t;

	// one bit per priority code, set while a routine of that level runs
	typedef logic [3:0] eipr_active_t;

endpackage : eipr_pkg

// ===== eipr_top.sv
// The address-and-strobe port was left to the implementer.
`include "eipr_map.svh"

module eipr_top (
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic [7:0]          addr,
	input  wire logic [7:0]          wdata,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [7:0]          rdata_q,
	input  wire logic                third_external_request_pin,
	input  wire logic                second_external_request_pin,
	input  wire logic                idle_mode,
	input  wire logic                power_down_mode,
	input  wire logic                global_irq_gate,
	input  wire logic [5:0]          base_irq_req,
	input  wire logic                serial_peripheral_done_flag,
	input  wire logic                converter_done_flag,
	input  wire logic                counter_array_req,
	input  wire logic                second_uart_req,
	input  wire logic                keypad_event_flag,
	input  wire logic                two_wire_serial_req,
	input  wire logic                timer_three_req,
	input  wire logic                brownout_b_flag,
	input  wire logic                brownout_a_flag,
	input  wire logic                watchdog_flag,
	input  wire logic                svc_start,
	input  wire logic                svc_done,
	output logic                     wake_q,
	output logic [15:0]              pending_q,
	output logic                     irq_req_q,
	output eipr_pkg::eipr_level_t    irq_level_q,
	output eipr_pkg::eipr_src_t      irq_src_q
);

	logic [7:0]             extra_external_irq_control_q;
	logic [6:0]             extended_irq_enable_1_q;
	logic                   timer_three_irq_enable_q;
	logic [2:0]             system_flag_irq_enable_q;
	logic [7:0]             base_priority_low_q;
	logic [7:0]             base_priority_high_q;
	logic [6:0]             extended_priority_low_1_q;
	logic [6:0]             extended_priority_high_1_q;
	logic                   third_prev_q;
	logic                   second_prev_q;
	eipr_pkg::eipr_active_t active_q;
	eipr_pkg::eipr_active_t active_d;
	logic                   third_det;
	logic                   second_det;
	logic                   wr_ctl;
	logic [15:0]            pend_c;
	logic [15:0]            prio_h;
	logic [15:0]            prio_l;
	eipr_pkg::eipr_level_t  best_lvl;
	eipr_pkg::eipr_src_t    best_src;
	logic                   found;
	logic                   allow_c;
	logic                   sysflag_c;
	logic                   wake_c;
	logic                   third_flag;
	logic                   second_flag;
	logic                   third_en;
	logic                   second_en;

	// active direction from polarity; power-down turns edges into levels
	function automatic logic eipr_detect(input logic pin, input logic prev,
		input logic pol, input logic typ, input logic pd);
		logic act;
		logic act_prev;
		act = pol ? pin : ~pin;
		act_prev = pol ? prev : ~prev;
		if (typ && !pd) begin
			return act && !act_prev;
		end
		return act;
	endfunction : eipr_detect

	function automatic eipr_pkg::eipr_level_t eipr_top_level(
		input eipr_pkg::eipr_active_t act);
		eipr_pkg::eipr_level_t lvl;
		lvl = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (act[i]) begin
				lvl = 2'(i);
			end
		end
		return lvl;
	endfunction : eipr_top_level

	assign wr_ctl      = wr_en && addr == `EIPR_ADR_EXTRA_EXT_CTL;
	assign third_flag  = extra_external_irq_control_q[`EIPR_B_THIRD_FLAG];
	assign second_flag = extra_external_irq_control_q[`EIPR_B_SECOND_FLAG];
	assign third_en    = extra_external_irq_control_q[`EIPR_B_THIRD_EN];
	assign second_en   = extra_external_irq_control_q[`EIPR_B_SECOND_EN];

	assign third_det = eipr_detect(third_external_request_pin, third_prev_q,
		extra_external_irq_control_q[`EIPR_B_THIRD_POL],
		extra_external_irq_control_q[`EIPR_B_THIRD_TYPE],
		power_down_mode);
	assign second_det = eipr_detect(second_external_request_pin,
		second_prev_q,
		extra_external_irq_control_q[`EIPR_B_SECOND_POL],
		extra_external_irq_control_q[`EIPR_B_SECOND_TYPE],
		power_down_mode);

	// pin history for edge detection
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			third_prev_q  <= 1'b0;
			second_prev_q <= 1'b0;
		end else begin
			third_prev_q  <= third_external_request_pin;
			second_prev_q <= second_external_request_pin;
		end
	end

	// control bits plus the two request flags; a detected event beats
	// any clear arriving in the same cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			extra_external_irq_control_q <= `EIPR_RST_BYTE;
		end else begin
			if (wr_ctl) begin
				extra_external_irq_control_q <= wdata;
			end else if (svc_start && irq_src_q == `EIPR_SRC_THIRD_EXT) begin
				extra_external_irq_control_q[`EIPR_B_THIRD_FLAG] <= 1'b0;
			end else if (svc_start &&
				irq_src_q == `EIPR_SRC_SECOND_EXT) begin
				extra_external_irq_control_q[`EIPR_B_SECOND_FLAG] <= 1'b0;
			end
			if (third_det) begin
				extra_external_irq_control_q[`EIPR_B_THIRD_FLAG] <= 1'b1;
			end
			if (second_det) begin
				extra_external_irq_control_q[`EIPR_B_SECOND_FLAG] <= 1'b1;
			end
		end
	end

	// enable and priority registers; reserved bits are not stored
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			extended_irq_enable_1_q    <= `EIPR_RST_SEVEN;
			timer_three_irq_enable_q   <= 1'b0;
			system_flag_irq_enable_q   <= `EIPR_RST_THREE;
			base_priority_low_q        <= `EIPR_RST_BYTE;
			base_priority_high_q       <= `EIPR_RST_BYTE;
			extended_priority_low_1_q  <= `EIPR_RST_SEVEN;
			extended_priority_high_1_q <= `EIPR_RST_SEVEN;
		end else if (wr_en) begin
			unique case (addr)
				`EIPR_ADR_EXT_ENABLE_1:
					extended_irq_enable_1_q <= wdata[6:0];
				`EIPR_ADR_EXT_ENABLE_2:
					timer_three_irq_enable_q <= wdata[0];
				`EIPR_ADR_SYS_FLAG_ENABLE:
					system_flag_irq_enable_q <= wdata[2:0];
				`EIPR_ADR_BASE_PRIO_LOW:
					base_priority_low_q <= wdata;
				`EIPR_ADR_BASE_PRIO_HIGH:
					base_priority_high_q <= wdata;
				`EIPR_ADR_EXT_PRIO_LOW_1:
					extended_priority_low_1_q <= wdata[6:0];
				`EIPR_ADR_EXT_PRIO_HIGH_1:
					extended_priority_high_1_q <= wdata[6:0];
				default: begin
				end
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= `EIPR_RST_BYTE;
		end else if (rd_en) begin
			unique case (addr)
				`EIPR_ADR_EXTRA_EXT_CTL:
					rdata_q <= extra_external_irq_control_q;
				`EIPR_ADR_EXT_ENABLE_1:
					rdata_q <= {1'b0, extended_irq_enable_1_q};
				`EIPR_ADR_EXT_ENABLE_2:
					rdata_q <= {7'h00, timer_three_irq_enable_q};
				`EIPR_ADR_SYS_FLAG_ENABLE:
					rdata_q <= {5'h00, system_flag_irq_enable_q};
				`EIPR_ADR_BASE_PRIO_LOW:
					rdata_q <= base_priority_low_q;
				`EIPR_ADR_BASE_PRIO_HIGH:
					rdata_q <= base_priority_high_q;
				`EIPR_ADR_EXT_PRIO_LOW_1:
					rdata_q <= {1'b0, extended_priority_low_1_q};
				`EIPR_ADR_EXT_PRIO_HIGH_1:
					rdata_q <= {1'b0, extended_priority_high_1_q};
				default:
					rdata_q <= `EIPR_RST_BYTE;
			endcase
		end else begin
			rdata_q <= `EIPR_RST_BYTE;
		end
	end

	assign sysflag_c = extended_irq_enable_1_q[`EIPR_B_SYSFLAG_EN] &&
		|({brownout_b_flag, brownout_a_flag, watchdog_flag} &
		system_flag_irq_enable_q);

	// source order matches the priority bit order of both register pairs
	assign pend_c = {
		timer_three_req && timer_three_irq_enable_q,
		two_wire_serial_req && extended_irq_enable_1_q[`EIPR_B_TWO_WIRE_SERIAL_EN],
		keypad_event_flag && extended_irq_enable_1_q[`EIPR_B_KEYPAD_EN],
		second_uart_req && extended_irq_enable_1_q[`EIPR_B_UART2_EN],
		sysflag_c,
		counter_array_req && extended_irq_enable_1_q[`EIPR_B_COUNTER_EN],
		converter_done_flag &&
			extended_irq_enable_1_q[`EIPR_B_CONVERTER_EN],
		serial_peripheral_done_flag &&
			extended_irq_enable_1_q[`EIPR_B_SERPER_EN],
		third_flag && third_en,
		second_flag && second_en,
		base_irq_req};

	// timer three has no priority bits here, so it always sits lowest
	assign prio_h = {1'b0, extended_priority_high_1_q,
		base_priority_high_q};
	assign prio_l = {1'b0, extended_priority_low_1_q,
		base_priority_low_q};

	// ties at one level go to the lowest source number
	always_comb begin
		best_lvl = 2'h0;
		best_src = 4'h0;
		found    = 1'b0;
		for (int i = 0; i < `EIPR_SRC_COUNT; i++) begin
			if (pend_c[i] && (!found || {prio_h[i], prio_l[i]} > best_lvl)) begin
				found    = 1'b1;
				best_lvl = {prio_h[i], prio_l[i]};
				best_src = 4'(i);
			end
		end
	end

	assign allow_c = found && global_irq_gate && (active_q == 4'h0 ||
		best_lvl > eipr_top_level(active_q));

	// nesting record: a return retires the most urgent running level
	always_comb begin
		active_d = active_q;
		if (svc_done && active_q != 4'h0) begin
			active_d[eipr_top_level(active_q)] = 1'b0;
		end
		if (svc_start) begin
			active_d[irq_level_q] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			active_q <= 4'h0;
		end else begin
			active_q <= active_d;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_req_q   <= 1'b0;
			irq_level_q <= 2'h0;
			irq_src_q   <= 4'h0;
			pending_q   <= 16'h0000;
		end else begin
			irq_req_q   <= allow_c;
			irq_level_q <= best_lvl;
			irq_src_q   <= best_src;
			pending_q   <= pend_c;
		end
	end

	// wake ignores the global gate so a sleeping core still resumes
	assign wake_c = (idle_mode || power_down_mode) &&
		((third_flag && third_en) || (second_flag && second_en));

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_c;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	third_high_level_a: assert property (
		!extra_external_irq_control_q[`EIPR_B_THIRD_TYPE] &&
		extra_external_irq_control_q[`EIPR_B_THIRD_POL] &&
		third_external_request_pin |=> third_flag)
		else $error("third input high level did not set its flag");

	third_edge_quiet_a: assert property (
		extra_external_irq_control_q[`EIPR_B_THIRD_TYPE] &&
		!power_down_mode && !third_flag && !wr_ctl &&
		$stable(third_external_request_pin) |=> !third_flag)
		else $error("third input edge mode set flag without an edge");

	second_low_level_a: assert property (
		!extra_external_irq_control_q[`EIPR_B_SECOND_TYPE] &&
		!extra_external_irq_control_q[`EIPR_B_SECOND_POL] &&
		!second_external_request_pin |=> second_flag)
		else $error("second input low level did not set its flag");

	second_fall_edge_a: assert property (
		extra_external_irq_control_q[`EIPR_B_SECOND_TYPE] &&
		!extra_external_irq_control_q[`EIPR_B_SECOND_POL] &&
		$fell(second_external_request_pin) |=> second_flag)
		else $error("second input falling edge missed");

	flag_sw_set_a: assert property (
		wr_ctl && wdata[`EIPR_B_THIRD_FLAG] |=> third_flag)
		else $error("software set of third flag lost");

	flag_svc_clear_a: assert property (
		svc_start && irq_src_q == `EIPR_SRC_THIRD_EXT && !wr_ctl &&
		!third_det |=> !third_flag)
		else $error("third flag not cleared at service start");

	wake_enabled_a: assert property (
		idle_mode && third_flag && third_en |=> wake_q)
		else $error("enabled third flag did not wake");

	wake_disabled_a: assert property (
		!(third_flag && third_en) && !(second_flag && second_en)
		|=> !wake_q)
		else $error("wake raised without an enabled flag");

	pd_as_level_a: assert property (
		power_down_mode &&
		extra_external_irq_control_q[`EIPR_B_THIRD_TYPE] &&
		extra_external_irq_control_q[`EIPR_B_THIRD_POL] &&
		third_external_request_pin |=> third_flag)
		else $error("power-down did not treat edge mode as level");

	keypad_gate_a: assert property (
		!extended_irq_enable_1_q[`EIPR_B_KEYPAD_EN]
		|=> !pending_q[`EIPR_SRC_KEYPAD])
		else $error("keypad request passed while disabled");

	sysflag_path_a: assert property (
		watchdog_flag && system_flag_irq_enable_q[0] &&
		extended_irq_enable_1_q[`EIPR_B_SYSFLAG_EN]
		|=> pending_q[`EIPR_SRC_SYSFLAG])
		else $error("system flag request missing");

	global_gate_a: assert property (
		!global_irq_gate |=> !irq_req_q)
		else $error("request raised with global gate closed");

	no_preempt_a: assert property (
		svc_start && !svc_done ##1 !svc_done
		|=> !irq_req_q || irq_level_q > $past(irq_level_q, 2))
		else $error("request did not outrank the running level");

	wake_seen_c: cover property (power_down_mode ##1 wake_q);
	nest_seen_c: cover property (svc_start ##2 irq_req_q);
	sysflag_seen_c: cover property (pending_q[`EIPR_SRC_SYSFLAG] && irq_req_q);
	top_level_c: cover property (irq_req_q && irq_level_q == 2'h3);

endmodule : eipr_top

// ===== eipr_core_model.sv
module eipr_core_model (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       irq_req_q,
	input  wire logic       accept,
	input  wire logic [1:0] lat,
	output logic            svc_start
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] seen_q;
	logic [2:0] hold_q;
	logic       go_q;
	// a taken level reaches irq_req_q late, so a hold stops a double take
	assign svc_start = go_q && irq_req_q;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seen_q <= 2'h0;
			hold_q <= 3'h0;
			go_q   <= 1'b0;
		end else if (hold_q != 3'h0 || svc_start) begin
			go_q   <= 1'b0;
			seen_q <= 2'h0;
			hold_q <= svc_start ? 3'h4 : hold_q - 3'h1;
		end else if (accept && irq_req_q) begin
			// lat sets how many cycles the core lets a request wait
			go_q   <= (seen_q == lat);
			seen_q <= seen_q + 2'h1;
		end else begin
			go_q   <= 1'b0;
			seen_q <= 2'h0;
		end
	end
endmodule : eipr_core_model

// ===== tb_eipr_top.sv
module tb_eipr_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, sys_rst, wr_en, rd_en, svc_start, svc_done;
	logic [7:0]  addr, wdata, rdata_q, rd, cfg;
	logic        pin_three, pin_two, idle_mode, power_down_mode;
	logic        global_irq_gate, timer_three_req, accept, wake_q;
	logic        irq_req_q;
	logic [5:0]  base_irq_req;
	logic [6:0]  per_req;
	logic [2:0]  sys_flags;
	logic [1:0]  lat, code;
	logic [15:0] pending_q;
	eipr_pkg::eipr_level_t irq_level_q;
	eipr_pkg::eipr_src_t   irq_src_q;
	int          failures, checked;
	localparam logic [7:0] adr [8] = '{8'had, 8'hae, 8'haf, 8'hb7,
		8'hb8, 8'hc0, 8'haa, 8'hab};
	localparam logic [7:0] msk [8] = '{8'h7f, 8'h7f, 8'h7f, 8'hff,
		8'hff, 8'hff, 8'h01, 8'h07};

	eipr_top i_eipr_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
		.third_external_request_pin(pin_three),
		.second_external_request_pin(pin_two), .idle_mode(idle_mode),
		.power_down_mode(power_down_mode),
		.global_irq_gate(global_irq_gate), .base_irq_req(base_irq_req),
		.serial_peripheral_done_flag(per_req[0]),
		.converter_done_flag(per_req[1]), .counter_array_req(per_req[2]),
		.second_uart_req(per_req[4]), .keypad_event_flag(per_req[5]),
		.two_wire_serial_req(per_req[6]), .timer_three_req(timer_three_req),
		.brownout_b_flag(sys_flags[2]), .brownout_a_flag(sys_flags[1]),
		.watchdog_flag(sys_flags[0]), .svc_start(svc_start),
		.svc_done(svc_done), .wake_q(wake_q), .pending_q(pending_q),
		.irq_req_q(irq_req_q), .irq_level_q(irq_level_q),
		.irq_src_q(irq_src_q));

	eipr_core_model i_eipr_core_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.irq_req_q(irq_req_q), .accept(accept), .lat(lat),
		.svc_start(svc_start));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask : fin

	// the extra leading edge keeps back-to-back calls from
	// assigning a strobe twice in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask : wr

	task automatic chkreg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		rd = rdata_q;
		chk({8'h00, rd}, {8'h00, exp});
	endtask : chkreg

	task automatic settle;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : settle

	task automatic set_pin(input int k, input logic v);
		@(posedge clk_sys);
		if (k != 0)
			pin_two <= v;
		else
			pin_three <= v;
	endtask : set_pin

	task automatic take(input logic [1:0] l);
		int n;
		@(posedge clk_sys);
		accept <= 1'b1;
		lat <= l;
		for (n = 0; n < 20 && svc_start !== 1'b1; n++)
			@(posedge clk_sys);
		chk(16'(svc_start), 16'h1);
		accept <= 1'b0;
	endtask : take

	initial begin
		#(50 * 20000);
		failures++;
		end_of_test;
	end

	initial begin
		sys_rst = 1'b1;
		{addr, wdata, base_irq_req, per_req, sys_flags, lat} = '0;
		{wr_en, rd_en, idle_mode, power_down_mode, svc_done, accept} = '0;
		{global_irq_gate, pin_three, pin_two, timer_three_req} = 4'hf;
		failures = 0;
		checked = 0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			chkreg(adr[i], 8'h00);
		wr(8'h01, 8'h5a);
		chkreg(8'h01, 8'h00);
		fin("reset");
		for (int i = 0; i < 8; i++) begin
			wr(adr[i], msk[i] & 8'h55);
			chkreg(adr[i], msk[i] & 8'h55);
			wr(adr[i], msk[i] & 8'haa);
			chkreg(adr[i], msk[i] & 8'haa);
			wr(adr[i], 8'h00);
		end
		fin("readback");
		for (int k = 0; k < 2; k++) begin
			cfg = (k != 0) ? 8'h05 : 8'hd0;
			wr(8'hc0, cfg);
			set_pin(k, k != 0);
			settle;
			chkreg(8'hc0, cfg);
			set_pin(k, k == 0);
			settle;
			chkreg(8'hc0, cfg | ((k != 0) ? 8'h02 : 8'h20));
			chk(16'(pending_q[(k != 0) ? 6 : 7]), 16'h1);
			if (k == 0)
				take(2'h0);
			else
				wr(8'hc0, cfg);
			settle;
			chkreg(8'hc0, cfg);
			set_pin(k, 1'b1);
		end
		@(posedge clk_sys);
		svc_done <= 1'b1;
		@(posedge clk_sys);
		svc_done <= 1'b0;
		fin("edges");
		set_pin(0, 1'b0);
		wr(8'hc0, 8'h40);
		settle;
		wr(8'hc0, 8'h40);
		chkreg(8'hc0, 8'h60);
		set_pin(0, 1'b1);
		settle;
		wr(8'hc0, 8'h40);
		chkreg(8'hc0, 8'h40);
		wr(8'hc0, 8'hd0);
		@(posedge clk_sys);
		power_down_mode <= 1'b1;
		settle;
		chkreg(8'hc0, 8'hf0);
		chk(16'(wake_q), 16'h1);
		@(posedge clk_sys);
		power_down_mode <= 1'b0;
		wr(8'hc0, 8'hd0);
		settle;
		chkreg(8'hc0, 8'hd0);
		@(posedge clk_sys);
		idle_mode <= 1'b1;
		wr(8'hc0, 8'h22);
		settle;
		chk(16'(wake_q), 16'h0);
		chkreg(8'hc0, 8'h22);
		wr(8'hc0, 8'h26);
		settle;
		chk(16'(wake_q), 16'h1);
		wr(8'hc0, 8'h62);
		settle;
		chk(16'(wake_q), 16'h1);
		@(posedge clk_sys);
		idle_mode <= 1'b0;
		set_pin(1, 1'b0);
		wr(8'hc0, 8'h04);
		settle;
		chkreg(8'hc0, 8'h06);
		chk(16'(pending_q[6]), 16'h1);
		set_pin(1, 1'b1);
		wr(8'hc0, 8'h00);
		fin("level and wake");
		@(posedge clk_sys);
		per_req <= 7'h7f;
		sys_flags <= 3'h7;
		wr(8'hab, 8'h07);
		for (int i = 0; i < 7; i++) begin
			wr(8'had, 8'(1 << i));
			settle;
			chk(pending_q & 16'hff00, 16'h0100 << i);
		end
		wr(8'had, 8'h00);
		wr(8'haa, 8'h01);
		settle;
		chk(pending_q & 16'hff00, 16'h8000);
		wr(8'had, 8'h08);
		for (int j = 0; j < 3; j++)
			for (int e = 0; e < 3; e++) begin
				@(posedge clk_sys);
				sys_flags <= 3'(1 << j);
				wr(8'hab, 8'(1 << e));
				settle;
				chk(16'(pending_q[11]), 16'(j == e));
			end
		fin("enables");
		@(posedge clk_sys);
		base_irq_req <= 6'h3f;
		wr(8'had, 8'h7f);
		wr(8'hab, 8'h07);
		wr(8'hc0, 8'h66);
		for (int k = 0; k < 15; k++) begin
			code = 2'(k % 3 + 1);
			cfg = 8'(1 << (k % 8));
			wr(8'hb7, (k < 8 && code[1]) ? cfg : 8'h00);
			wr(8'hb8, (k < 8 && code[0]) ? cfg : 8'h00);
			wr(8'haf, (k >= 8 && code[1]) ? cfg : 8'h00);
			wr(8'hae, (k >= 8 && code[0]) ? cfg : 8'h00);
			settle;
			chk({9'h0, irq_req_q, irq_src_q, irq_level_q},
				{9'h0, 1'b1, 4'(k), code});
		end
		@(posedge clk_sys);
		global_irq_gate <= 1'b0;
		settle;
		chk(16'(irq_req_q), 16'h0);
		chk(pending_q, 16'hffff);
		@(posedge clk_sys);
		global_irq_gate <= 1'b1;
		fin("priority");
		wr(8'hb7, 8'h20);
		wr(8'hb8, 8'h00);
		wr(8'haf, 8'h00);
		wr(8'hae, 8'h00);
		settle;
		chk({12'h0, irq_src_q}, 16'h5);
		take(2'h3);
		settle;
		chk(16'(irq_req_q), 16'h0);
		wr(8'hb7, 8'h21);
		settle;
		chk(16'(irq_req_q), 16'h0);
		wr(8'hb8, 8'h01);
		settle;
		chk({9'h0, irq_req_q, irq_src_q, irq_level_q},
			{9'h0, 1'b1, 4'h0, 2'h3});
		fin("preemption");
		end_of_test;
	end
endmodule : tb_eipr_top
